// *** timer_port_ctrl.sv ***
// Purpose: Timer configuration register, shared prescaler routing and the
//          first five-pin I/O port with its direction register.
// Assumes: One clock; register port with read data one cycle after strobe.
// Notes:   Pin inputs are synchronised before any logic reads them.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module timer_port_ctrl #(
  parameter int INSTR_DIV = timer_port_pkg::INSTR_CYCLE_DIV
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [4:0] port_pin_in,
  output logic [4:0] port_pin_out,
  output logic [4:0] port_pin_oe,
  input wire logic ext_interrupt_pin,
  input wire logic [7:0] second_port_latch,
  output logic [7:0] pullup_en,
  input wire logic watchdog_raw_tick,
  output logic timer_inc,
  output logic watchdog_tick,
  output logic ext_irq_pulse,
  output logic instr_cycle_clock
);

  if (INSTR_DIV < 2 || INSTR_DIV > 256) begin : div_range_chk
    $error("INSTR_DIV must lie between 2 and 256");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [4:0] pins_s;
  logic [0:0] irq_pin_s;

  pin_sync2 #(.WIDTH(timer_port_pkg::PORT_WIDTH)) port_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(port_pin_in),
    .sync_out(pins_s)
  );

  pin_sync2 #(.WIDTH(1)) irq_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(ext_interrupt_pin),
    .sync_out(irq_pin_s)
  );

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [4:0] dir_r;
  logic [4:0] dir_nxt;
  logic [4:0] latch_r;
  logic [4:0] latch_nxt;
  logic bank_r;
  logic bank_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] eff_addr;
  logic cfg_wr;

  assign eff_addr = {bank_r, addr[6:0]};
  assign cfg_wr = wr_en && eff_addr == timer_port_pkg::TIMER_CONFIG_ADDR;

  // Decodes an effective address into the value software reads.
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a[6:0] == timer_port_pkg::BANK_STATUS_ADDR) begin
      v[timer_port_pkg::BANK_SELECT_BIT] = bank_r;
    end else if (a == timer_port_pkg::FIRST_PORT_DATA_ADDR) begin
      v = {3'b000, pins_s};
    end else if (a == timer_port_pkg::TIMER_CONFIG_ADDR) begin
      v = cfg_r;
    end else if (a == timer_port_pkg::FIRST_PORT_DIRECTION_ADDR) begin
      v = {3'b000, dir_r};
    end
    return v;
  endfunction

  // Register writes, port modify and the one-cycle read answer.
  always_comb begin
    cfg_nxt = cfg_r;
    dir_nxt = dir_r;
    latch_nxt = latch_r;
    bank_nxt = bank_r;
    rdata_nxt = rd_en ? read_mux(eff_addr) : 8'h00;
    if (wr_en) begin
      if (eff_addr[6:0] == timer_port_pkg::BANK_STATUS_ADDR) begin
        bank_nxt = wdata[timer_port_pkg::BANK_SELECT_BIT];
      end
      if (cfg_wr) begin
        cfg_nxt = wdata;
      end
      if (eff_addr == timer_port_pkg::FIRST_PORT_DIRECTION_ADDR) begin
        dir_nxt = wdata[4:0];
      end
      // whole-port write replaces every latch bit
      if (eff_addr == timer_port_pkg::FIRST_PORT_DATA_ADDR) begin
        latch_nxt = wdata[4:0];
      end
      // bit modify reads pins, changes one bit, stores latch
      if (eff_addr == timer_port_pkg::PORT_BIT_MODIFY_ADDR &&
          wdata[2:0] < 3'h5) begin
        latch_nxt = pins_s;
        latch_nxt[wdata[2:0]] = wdata[timer_port_pkg::BIT_MODIFY_VALUE_BIT];
      end
    end
  end

  // Reset puts every port pin in input mode and the config to all ones.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_r <= timer_port_pkg::TIMER_CONFIG_RESET;
      dir_r <= timer_port_pkg::DIRECTION_RESET;
      latch_r <= timer_port_pkg::LATCH_RESET;
      bank_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      cfg_r <= cfg_nxt;
      dir_r <= dir_nxt;
      latch_r <= latch_nxt;
      bank_r <= bank_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // ----------------------------------------------------------------------
  // Pin drivers and pull-ups
  // ----------------------------------------------------------------------
  // direction one tristates the driver
  assign port_pin_out[3:0] = latch_r[3:0];
  assign port_pin_oe[3:0] = ~dir_r[3:0];
  // pin 4 pulls low only, so it drives just when a zero is latched
  assign port_pin_out[4] = 1'b0;
  assign port_pin_oe[4] = ~dir_r[4] & ~latch_r[4];
  // pull-ups follow the second port's latch unless disabled
  assign pullup_en = cfg_r[timer_port_pkg::PULLUP_DISABLE_N_BIT] ?
                     8'h00 : second_port_latch;

  // ----------------------------------------------------------------------
  // Instruction cycle divider and edge detection
  // ----------------------------------------------------------------------
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic icyc_en;
  logic pin4_d_r;
  logic pin4_d_nxt;
  logic irq_d_r;
  logic irq_d_nxt;
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;
  logic armed;
  logic ext_edge;
  logic src_tick;
  logic irq_edge;

  // The cycle clock is an enable, one ref_clk period out of INSTR_DIV.
  // Edges stay masked until the synchronisers hold real pin levels.
  always_comb begin
    icyc_en = div_r == 8'(INSTR_DIV - 1);
    div_nxt = icyc_en ? 8'h00 : 8'(div_r + 8'h01);
    armed = settle_r == 2'h3;
    settle_nxt = armed ? settle_r : 2'(settle_r + 2'h1);
    pin4_d_nxt = pins_s[timer_port_pkg::OPEN_DRAIN_PIN];
    irq_d_nxt = irq_pin_s[0];
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_r <= 8'h00;
      settle_r <= 2'h0;
      pin4_d_r <= 1'b0;
      irq_d_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      settle_r <= settle_nxt;
      pin4_d_r <= pin4_d_nxt;
      irq_d_r <= irq_d_nxt;
    end
  end

  // pin 4 level also feeds the timer edge path
  assign ext_edge = armed & (cfg_r[timer_port_pkg::TIMER_SRC_EDGE_BIT] ?
                    (pin4_d_r & ~pins_s[4]) : (~pin4_d_r & pins_s[4]));
  // choose pin edges or cycle clock
  assign src_tick = cfg_r[timer_port_pkg::TIMER_SRC_SEL_BIT] ?
                    ext_edge : icyc_en;
  assign irq_edge = armed & (cfg_r[timer_port_pkg::EXT_IRQ_EDGE_SEL_BIT] ?
                    (~irq_d_r & irq_pin_s[0]) : (irq_d_r & ~irq_pin_s[0]));

  // ----------------------------------------------------------------------
  // Shared prescaler routing
  // ----------------------------------------------------------------------
  logic prescale_assign;
  logic [2:0] rate;
  logic [3:0] pre_shift;
  logic pre_in;
  logic pre_out;
  logic timer_inc_r;
  logic timer_inc_nxt;
  logic wdt_tick_r;
  logic wdt_tick_nxt;
  logic irq_r;
  logic irq_nxt;
  logic icyc_r;
  logic icyc_nxt;

  assign prescale_assign = cfg_r[timer_port_pkg::PRESCALE_ASSIGN_BIT];
  assign rate = cfg_r[timer_port_pkg::PRESCALE_RATE_LSB +: 3];
  // timer ratios start at 1:2, watchdog ratios at 1:1
  assign pre_shift = prescale_assign ? {1'b0, rate} : 4'({1'b0, rate} + 4'h1);
  assign pre_in = prescale_assign ? watchdog_raw_tick : src_tick;

  // Clearing on any config write avoids a stray early tick after a change.
  shared_prescaler prescale (
    .ref_clk(ref_clk),
    .srst(srst),
    .clr(cfg_wr),
    .tick_in(pre_in),
    .shift(pre_shift),
    .tick_out(pre_out)
  );

  // with prescaler on the watchdog the timer counts undivided
  always_comb begin
    timer_inc_nxt = prescale_assign ? src_tick : pre_out;
    wdt_tick_nxt = prescale_assign ? pre_out : watchdog_raw_tick;
    irq_nxt = irq_edge;
    icyc_nxt = icyc_en;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timer_inc_r <= 1'b0;
      wdt_tick_r <= 1'b0;
      irq_r <= 1'b0;
      icyc_r <= 1'b0;
    end else begin
      timer_inc_r <= timer_inc_nxt;
      wdt_tick_r <= wdt_tick_nxt;
      irq_r <= irq_nxt;
      icyc_r <= icyc_nxt;
    end
  end

  assign timer_inc = timer_inc_r;
  assign watchdog_tick = wdt_tick_r;
  assign ext_irq_pulse = irq_r;
  assign instr_cycle_clock = icyc_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  pullup_off_a: assert property (cfg_r[7] |-> pullup_en == 8'h00)
    else $error("pull-ups active while disabled");
  irq_rise_a: assert property (
    (armed && cfg_r[6] && !irq_d_r && irq_pin_s[0]) |=> ext_irq_pulse)
    else $error("rising interrupt edge missed");
  cycle_src_a: assert property (
    (!cfg_r[5] && prescale_assign && icyc_en) |=> timer_inc)
    else $error("cycle clock did not reach timer");
  ext_fall_a: assert property (
    (armed && cfg_r[5] && cfg_r[4] && prescale_assign && pin4_d_r && !pins_s[4])
    |=> timer_inc)
    else $error("falling pin edge not counted");
  wdt_route_a: assert property (
    (!prescale_assign && watchdog_raw_tick) |=> watchdog_tick)
    else $error("watchdog tick lost without prescaler");
  rate_one_a: assert property (
    (prescale_assign && rate == 3'h0 && watchdog_raw_tick) |=> watchdog_tick)
    else $error("watchdog 1:1 ratio broken");
  cfg_reset_a: assert property (@(posedge ref_clk)
    $past(srst) |-> cfg_r == timer_port_pkg::TIMER_CONFIG_RESET)
    else $error("config reset value wrong");
  od_pin_a: assert property (port_pin_out[4] == 1'b0)
    else $error("open-drain pin drove high");
  drive_dir_a: assert property (
    $rose(dir_r[0]) |-> !port_pin_oe[0])
    else $error("input pin still driven");
  read_pins_a: assert property (
    (rd_en && eff_addr == 8'h05) |=> rdata == {3'b000, $past(pins_s)})
    else $error("port read did not return pins");
  dir_reset_a: assert property (@(posedge ref_clk)
    $past(srst) |-> dir_r == timer_port_pkg::DIRECTION_RESET)
    else $error("direction not all inputs after reset");
  bank_gate_a: assert property (
    (wr_en && !bank_r && addr == 8'h05) |=> $stable(dir_r))
    else $error("bank zero write reached direction");

endmodule
`default_nettype wire

// *** timer_port_pkg.sv ***
// Purpose: Shared constants for the timer configuration and first I/O port.
// Assumes: 8-bit register port, 8-bit file addresses including the bank bit.
// Notes:   Named offsets, field positions, reset values and counts live here; the controller also uses some as bare literals.
package timer_port_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] FIRST_PORT_DATA_ADDR = 8'h05;
  localparam logic [7:0] TIMER_CONFIG_ADDR = 8'h81;
  localparam logic [7:0] FIRST_PORT_DIRECTION_ADDR = 8'h85;
  localparam logic [6:0] BANK_STATUS_ADDR = 7'h03;
  localparam logic [7:0] PORT_BIT_MODIFY_ADDR = 8'h08;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PULLUP_DISABLE_N_BIT = 7;
  localparam int EXT_IRQ_EDGE_SEL_BIT = 6;
  localparam int TIMER_SRC_SEL_BIT = 5;
  localparam int TIMER_SRC_EDGE_BIT = 4;
  localparam int PRESCALE_ASSIGN_BIT = 3;
  localparam int PRESCALE_RATE_LSB = 0;
  localparam int BANK_SELECT_BIT = 5;
  localparam int BIT_MODIFY_VALUE_BIT = 7;
  localparam int OPEN_DRAIN_PIN = 4;
  localparam int EXT_INTERRUPT_PIN = 0;

  // ----------------------------------------------------------------------
  // Widths, reset values and timing
  // ----------------------------------------------------------------------
  localparam int PORT_WIDTH = 5;
  localparam int SECOND_PORT_WIDTH = 8;
  localparam logic [7:0] TIMER_CONFIG_RESET = 8'hff;
  localparam logic [4:0] DIRECTION_RESET = 5'h1f;
  localparam logic [4:0] LATCH_RESET = 5'h00;
  localparam int INSTR_CYCLE_DIV = 4;

endpackage

// *** pin_sync2.sv ***
// Purpose: Two-stage synchroniser for a group of pin levels.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/10ps
`default_nettype none
module pin_sync2 #(
  parameter int WIDTH = 5
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // The first stage feeds the second and nothing else.
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule
`default_nettype wire

// *** shared_prescaler.sv ***
// Purpose: Shared power-of-two prescaler for the timer or the watchdog.
// Assumes: tick_in is a one-cycle pulse on ref_clk.
// Notes:   A shift of zero passes every input tick straight through.
`timescale 1ns/10ps
`default_nettype none
module shared_prescaler (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clr,
  input wire logic tick_in,
  input wire logic [3:0] shift,
  output logic tick_out
);

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] mask;
  logic wrap;

  // The counter wraps once every 2**shift input ticks.
  always_comb begin
    mask = 8'((9'h001 << shift) - 9'h001);
    wrap = &(count_r | ~mask);
    tick_out = tick_in & wrap;
    count_nxt = count_r;
    if (clr) begin
      count_nxt = 8'h00;
    end else if (tick_in) begin
      count_nxt = wrap ? 8'h00 : 8'(count_r + 8'h01);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_r <= 8'h00;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule
`default_nettype wire

// *** pin_model.sv ***
// Purpose: Pin and watchdog-core model at the far side of the port block.
// Assumes: Same clock as the block; the bench picks external pin levels.
// Notes:   Released pins 3..0 float and toggle every cycle; pin 4 has a
//          pull-up, so it reads high whenever nothing pulls it low.
`timescale 1ns/10ps
`default_nettype none
module pin_model (
  input wire logic ref_clk,
  input wire logic [4:0] port_pin_out,
  input wire logic [4:0] port_pin_oe,
  input wire logic [4:0] ext_level,
  input wire logic [4:0] ext_drive,
  output logic [4:0] port_pin_in,
  output logic watchdog_raw_tick
);
  logic flip_r = 1'b0;

  // ------------------------------------------------------------------
  // Watchdog raw tick, one cycle high in every two.
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    flip_r <= ~flip_r;
  end
  assign watchdog_raw_tick = flip_r;

  // ------------------------------------------------------------------
  // Pin levels resolved from both parties.
  // ------------------------------------------------------------------
  // tristate and open drain.
  // A floating pin toggles so that a stale value can never pass a read.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      port_pin_in[i] = port_pin_oe[i] ? port_pin_out[i] :
                       (ext_drive[i] ? ext_level[i] : flip_r);
    end
    port_pin_in[4] = (port_pin_oe[4] && !port_pin_out[4]) ? 1'b0 :
                     (ext_drive[4] ? ext_level[4] : 1'b1);
  end
endmodule
`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the timer configuration and first port.
// Assumes: Bank bit 5 of the status register at 03 selects bank 1.
// Notes:   Pulse counts carry one count of slack for prescaler phase.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pullup_en;
  logic [7:0] second_port_latch = 8'h5a;
  logic [4:0] port_pin_in, port_pin_out, port_pin_oe;
  logic [4:0] ext_level = 5'h00, ext_drive = 5'h00;
  logic ext_interrupt_pin = 1'b1, watchdog_raw_tick;
  logic timer_inc, watchdog_tick, ext_irq_pulse, instr_cycle_clock;
  int err_count = 0, checks_done = 0, ti_cnt = 0, wd_cnt = 0, irq_cnt = 0;
  int ic_cnt = 0;

  timer_port_ctrl #(.INSTR_DIV(4)) DUT (.ref_clk(ref_clk), .srst(srst),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
    .port_pin_oe(port_pin_oe), .ext_interrupt_pin(ext_interrupt_pin),
    .second_port_latch(second_port_latch), .pullup_en(pullup_en),
    .watchdog_raw_tick(watchdog_raw_tick), .timer_inc(timer_inc),
    .watchdog_tick(watchdog_tick), .ext_irq_pulse(ext_irq_pulse),
    .instr_cycle_clock(instr_cycle_clock));

  pin_model partner (.ref_clk(ref_clk), .port_pin_out(port_pin_out),
    .port_pin_oe(port_pin_oe), .ext_level(ext_level),
    .ext_drive(ext_drive), .port_pin_in(port_pin_in),
    .watchdog_raw_tick(watchdog_raw_tick));

  // ------------------------------------------------------------------
  // Clock and pulse counters.
  // ------------------------------------------------------------------
  always #2 ref_clk = ~ref_clk;
  // Pulses are counted at the falling edge, where they have settled.
  always @(negedge ref_clk) begin
    ti_cnt += int'(timer_inc === 1'b1);
    wd_cnt += int'(watchdog_tick === 1'b1);
    irq_cnt += int'(ext_irq_pulse === 1'b1);
    ic_cnt += int'(instr_cycle_clock === 1'b1);
  end

  // ------------------------------------------------------------------
  // Shared tasks.
  // ------------------------------------------------------------------
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bus tasks start and end on a rising edge; the closing edge keeps the
  // next request from reassigning a strobe in the same time step.
  task automatic wr(logic [7:0] a, logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Read data stand only in the cycle after the strobe and are taken at
  // the edge that closes that cycle.
  task automatic rd_chk(string name, logic [7:0] a, logic [7:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    check(name, rdata, exp);
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic zero();
    ti_cnt = 0;
    wd_cnt = 0;
    irq_cnt = 0;
    ic_cnt = 0;
  endtask

  task automatic in_range(string name, int c, int e);
    check(name, 8'(c >= e - 1 && c <= e + 1), 8'h01);
  endtask

  task automatic test_done();
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------------
  task automatic reset_values();
    check("oe", 8'(port_pin_oe), 8'h00);
    check("pullup", pullup_en, 8'h00);
    rd_chk("status", 8'h03, 8'h00);
    wr(8'h03, 8'h20);
    rd_chk("status1", 8'h83, 8'h20);
    rd_chk("cfg_rst", 8'h81, 8'hff);
    rd_chk("dir_rst", 8'h85, 8'h1f);
    rd_chk("unmapped", 8'h8e, 8'h00);
  endtask

  task automatic config_rw();
    wr(8'h81, 8'ha5);
    rd_chk("cfg_a5", 8'h81, 8'ha5);
    wr(8'h81, 8'h5a);
    rd_chk("cfg_5a", 8'h81, 8'h5a);
    check("pullup_on", pullup_en, second_port_latch);
    wr(8'h81, 8'h80);
    check("pullup_off", pullup_en, 8'h00);
  endtask

  task automatic port_drive();
    wr(8'h03, 8'h00);
    wr(8'h05, 8'hea);
    wr(8'h03, 8'h20);
    wr(8'h85, 8'he0);
    rd_chk("dir_upper", 8'h85, 8'h00);
    check("oe_all", 8'(port_pin_oe), 8'h1f);
    check("out_lo", 8'(port_pin_out[3:0]), 8'h0a);
    wr(8'h03, 8'h00);
    idle(4);
    rd_chk("pins_a", 8'h05, 8'h0a);
    wr(8'h05, 8'h10);
    check("oe_od", 8'(port_pin_oe), 8'h0f);
    check("out4", 8'(port_pin_out[4]), 8'h00);
    idle(4);
    rd_chk("pins_pu", 8'h05, 8'h10);
  endtask

  task automatic port_rmw();
    wr(8'h03, 8'h20);
    wr(8'h85, 8'hff);
    rd_chk("dir_ff", 8'h85, 8'h1f);
    check("oe_off", 8'(port_pin_oe), 8'h00);
    ext_drive <= 5'h0f;
    ext_level <= 5'h05;
    wr(8'h03, 8'h00);
    idle(4);
    rd_chk("pins_in", 8'h05, 8'h15);
    wr(8'h08, 8'h81);
    // An index above pin 4 must leave the latch alone.
    wr(8'h08, 8'h07);
    ext_drive <= 5'h00;
    wr(8'h03, 8'h20);
    wr(8'h85, 8'h00);
    check("rmw_out", 8'(port_pin_out[3:0]), 8'h07);
    check("rmw_oe", 8'(port_pin_oe), 8'h0f);
    wr(8'h85, 8'hff);
  endtask

  // Pin 4 and the interrupt pin move together; edge bits chosen by m.
  task automatic edges();
    for (int m = 0; m < 2; m++) begin
      wr(8'h81, m ? 8'h38 : 8'h68);
      ext_drive <= 5'h10;
      ext_level <= 5'h10;
      ext_interrupt_pin <= 1'b1;
      idle(8);
      zero();
      ext_level <= 5'h00;
      ext_interrupt_pin <= 1'b0;
      idle(8);
      check("t_fall", 8'(ti_cnt), 8'(m));
      check("i_fall", 8'(irq_cnt), 8'(m));
      ext_level <= 5'h10;
      ext_interrupt_pin <= 1'b1;
      idle(8);
      check("t_rise", 8'(ti_cnt), 8'h01);
      check("i_rise", 8'(irq_cnt), 8'h01);
    end
    ext_drive <= 5'h00;
  endtask

  task automatic prescale();
    // prescaler on the watchdog gives the timer 1:1.
    wr(8'h81, 8'h08);
    zero();
    idle(80);
    in_range("t_1to1", ti_cnt, 20);
    in_range("icyc", ic_cnt, 20);
    // The timer divides the cycle clock, one tick in four, by 2 << r.
    for (int r = 0; r < 3; r++) begin
      wr(8'h81, 8'(r));
      zero();
      idle(64 << r);
      in_range("t_rate", ti_cnt, 8);
      in_range("w_psa0", wd_cnt, 32 << r);
      wr(8'h81, 8'(8 + r));
      zero();
      idle(16 << r);
      in_range("w_rate", wd_cnt, 8);
    end
  endtask

  // A second reset in mid-run must restore the reset state.
  task automatic mid_reset();
    wr(8'h03, 8'h20);
    wr(8'h85, 8'h00);
    srst <= 1'b1;
    idle(2);
    srst <= 1'b0;
    idle(2);
    check("oe_rst2", 8'(port_pin_oe), 8'h00);
    rd_chk("bank_rst2", 8'h03, 8'h00);
    wr(8'h03, 8'h20);
    rd_chk("cfg_rst2", 8'h81, 8'hff);
    rd_chk("dir_rst2", 8'h85, 8'h1f);
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog.
  // ------------------------------------------------------------------
  initial begin
    idle(12);
    srst <= 1'b0;
    idle(2);
    reset_values();
    config_rw();
    port_drive();
    port_rmw();
    edges();
    prescale();
    mid_reset();
    test_done();
  end

  initial begin
    #40000;
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
